// ===== hw/cce_exec.sv
// Decided for this implementation: strobed register access and the register addresses.
`include "cce_defs.svh"

module cce_exec #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // instruction from fetch, held for the whole instruction cycle
  input wire logic [`CCE_INSN_W-1:0] instr_i,
  input wire logic instr_valid_i,
  // file register port
  output logic [ADDR_W-1:0] file_addr_o,
  output logic file_rd_o,
  input wire logic [DATA_W-1:0] file_rdata_i,
  output logic file_we_o,
  output logic [DATA_W-1:0] file_wdata_o,
  // watchdog and power events
  output logic watchdog_clr_o,
  output logic prescaler_clr_o,
  input wire logic timeout_evt_i,
  input wire logic sleep_evt_i,
  // core state
  output logic [DATA_W-1:0] w_o,
  output logic z_flag_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o,
  output logic insn_done_o,
  // register port
  input wire logic [`CCE_REG_AW-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    if ((DATA_W != 8) || (ADDR_W != `CCE_FADDR_MSB + 1))
    begin : g_bad_param
      $error("cce_exec: DATA_W must be 8, ADDR_W the file address width");
    end
  endgenerate

  // ****************************************************************
  // state
  // ****************************************************************
  cce_pkg::cce_phase_t phase;
  cce_pkg::cce_op_t op;
  cce_pkg::cce_op_t next_op;
  logic [`CCE_INSN_W-1:0] insn;
  logic [DATA_W-1:0] result;
  logic exec_en;
  logic [`CCE_COUNT_W-1:0] exec_count;
  logic q4_now;
  logic dest_file;

  assign q4_now = (phase == cce_pkg::q4_write);
  assign dest_file = insn[`CCE_SEL_BIT];

  // ****************************************************************
  // phase sequencer: one instruction cycle is four clocks
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      phase <= cce_pkg::q1_decode;
    else
    begin
      case (phase)
        cce_pkg::q1_decode: phase <= cce_pkg::q2_read;
        cce_pkg::q2_read: phase <= cce_pkg::q3_process;
        cce_pkg::q3_process: phase <= cce_pkg::q4_write;
        default: phase <= cce_pkg::q1_decode;
      endcase
    end
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  // anything outside the four handled encodings runs as a no-op here
  always_comb
  begin
    next_op = cce_pkg::op_none;
    if (instr_valid_i && exec_en)
    begin
      if (instr_i == `CCE_INSN_WATCHDOG_CLEAR)
        next_op = cce_pkg::watchdog_clear_op;
      else if (instr_i[`CCE_OPC_MSB:`CCE_OPC_LSB] == `CCE_OPC_CLEAR)
        next_op = instr_i[`CCE_SEL_BIT] ? cce_pkg::clear_file_register_op :
                  cce_pkg::clear_accumulator_op;
      else if (instr_i[`CCE_OPC_MSB:`CCE_OPC_LSB] == `CCE_OPC_COMPLEMENT)
        next_op = cce_pkg::complement_file_op;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      op <= cce_pkg::op_none;
      insn <= '0;
    end
    else if (phase == cce_pkg::q1_decode)
    begin
      op <= next_op;
      insn <= instr_i;
    end
  end

  // ****************************************************************
  // file read in q2, operand processing in q3
  // ****************************************************************
  // clear-accumulator raises neither file_rd_o nor file_we_o; file_addr_o still loads in q2
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      file_rd_o <= 1'b0;
      file_addr_o <= '0;
    end
    else if (phase == cce_pkg::q2_read)
    begin
      file_rd_o <= (op == cce_pkg::clear_file_register_op) ||
                   (op == cce_pkg::complement_file_op);
      file_addr_o <= insn[ADDR_W-1:0];
    end
    else
      file_rd_o <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      result <= '0;
    else if (phase == cce_pkg::q3_process)
      result <= (op == cce_pkg::complement_file_op) ?
                ~file_rdata_i : '0;
  end

  // ****************************************************************
  // q4 write-back
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      file_we_o <= 1'b0;
      file_wdata_o <= '0;
    end
    else
    begin
      file_we_o <= q4_now &&
                   ((op == cce_pkg::clear_file_register_op) ||
                    ((op == cce_pkg::complement_file_op) && dest_file));
      if (q4_now)
        file_wdata_o <= result;
    end
  end

  // hardware write-back wins over a bus write in the same clock
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      w_o <= '0;
    else if (q4_now && (op == cce_pkg::clear_accumulator_op))
      w_o <= '0;
    else if (q4_now && (op == cce_pkg::complement_file_op) && !dest_file)
      w_o <= result;
    else if (reg_wr_i && (reg_addr_i == `CCE_REG_WORK))
      w_o <= reg_wdata_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      z_flag_o <= `CCE_RST_ZERO_FLAG;
    else if (q4_now && ((op == cce_pkg::clear_file_register_op) ||
                        (op == cce_pkg::clear_accumulator_op)))
      z_flag_o <= 1'b1;
    else if (q4_now && (op == cce_pkg::complement_file_op))
      z_flag_o <= (result == '0);
    else if (reg_wr_i && (reg_addr_i == `CCE_REG_STATUS))
      z_flag_o <= reg_wdata_i[`CCE_ST_ZERO];
  end

  // ****************************************************************
  // watchdog clear and the active-low status flags
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      watchdog_clr_o <= 1'b0;
      prescaler_clr_o <= 1'b0;
    end
    else
    begin
      watchdog_clr_o <= q4_now && (op == cce_pkg::watchdog_clear_op);
      prescaler_clr_o <= q4_now && (op == cce_pkg::watchdog_clear_op);
    end
  end

  // a time-out or sleep in the same clock beats the clear; no event is lost
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      timeout_flag_n_o <= `CCE_RST_FLAG_N;
    else if (timeout_evt_i)
      timeout_flag_n_o <= 1'b0;
    else if (q4_now && (op == cce_pkg::watchdog_clear_op))
      timeout_flag_n_o <= 1'b1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      powerdown_flag_n_o <= `CCE_RST_FLAG_N;
    else if (sleep_evt_i)
      powerdown_flag_n_o <= 1'b0;
    else if (q4_now && (op == cce_pkg::watchdog_clear_op))
      powerdown_flag_n_o <= 1'b1;
  end

  // ****************************************************************
  // completion and execution counter
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      insn_done_o <= 1'b0;
    else
      insn_done_o <= q4_now && (op != cce_pkg::op_none);
  end

  // counter wraps; a bus write to it clears it unless an instruction completes in the same clock
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      exec_count <= '0;
    else if (q4_now && (op != cce_pkg::op_none))
      exec_count <= exec_count + `CCE_COUNT_W'(1);
    else if (reg_wr_i && (reg_addr_i == `CCE_REG_COUNT))
      exec_count <= '0;
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      exec_en <= `CCE_RST_EXEC_EN;
    else if (reg_wr_i && (reg_addr_i == `CCE_REG_CTRL))
      exec_en <= reg_wdata_i[`CCE_CTRL_EXEC_EN];
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || !reg_rd_i)
      reg_rdata_o <= '0;
    else if (reg_addr_i == `CCE_REG_WORK)
      reg_rdata_o <= w_o;
    else if (reg_addr_i == `CCE_REG_STATUS)
    begin
      reg_rdata_o <= '0;
      reg_rdata_o[`CCE_ST_ZERO] <= z_flag_o;
      reg_rdata_o[`CCE_ST_POWERDOWN] <= powerdown_flag_n_o;
      reg_rdata_o[`CCE_ST_TIMEOUT] <= timeout_flag_n_o;
    end
    else if (reg_addr_i == `CCE_REG_CTRL)
    begin
      reg_rdata_o <= '0;
      reg_rdata_o[`CCE_CTRL_EXEC_EN] <= exec_en;
    end
    else if (reg_addr_i == `CCE_REG_COUNT)
      reg_rdata_o <= exec_count;
    else
      reg_rdata_o <= '0;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_clear_file_zero: assert property (
    (q4_now && (op == cce_pkg::clear_file_register_op))
    |=> (file_we_o && (file_wdata_o == '0) && z_flag_o &&
         (file_addr_o == insn[ADDR_W-1:0])))
    else $error("clear-file did not write zero with zero flag");
  chk_watchdog_pulse: assert property (
    ((phase == cce_pkg::q1_decode) &&
     (next_op == cce_pkg::watchdog_clear_op))
    |-> ##1 (!watchdog_clr_o) [*3] ##1 (watchdog_clr_o && prescaler_clr_o)
    ##1 !watchdog_clr_o)
    else $error("watchdog clear not pulsed at end of cycle");
  chk_watchdog_flags: assert property (
    (q4_now && (op == cce_pkg::watchdog_clear_op) &&
     !timeout_evt_i && !sleep_evt_i)
    |=> (timeout_flag_n_o && powerdown_flag_n_o && prescaler_clr_o))
    else $error("watchdog clear did not set status flags");
  chk_complement_result: assert property (
    ((phase == cce_pkg::q3_process) &&
     (op == cce_pkg::complement_file_op))
    |-> ##2 ((dest_file ?
      (file_we_o && (file_wdata_o == ~$past(file_rdata_i, 2))) :
      (!file_we_o && (w_o == ~$past(file_rdata_i, 2)))) &&
      (z_flag_o == ($past(file_rdata_i, 2) == '1))))
    else $error("complement result or destination wrong");
  chk_accum_no_read: assert property (
    ((phase == cce_pkg::q1_decode) &&
     (next_op == cce_pkg::clear_accumulator_op))
    |-> ##1 (!file_rd_o && !file_we_o) [*4] ##0 ((w_o == '0) && z_flag_o))
    else $error("clear-accumulator read a file or left W nonzero");
  chk_phase_wrap: assert property (
    q4_now |=> (phase == cce_pkg::q1_decode) ##1 (phase == cce_pkg::q2_read))
    else $error("instruction cycle is not four clocks");
  chk_read_idle: assert property (!reg_rd_i |=> (reg_rdata_o == '0))
    else $error("read data present without a read strobe");
  chk_count_step: assert property (
    (q4_now && (op != cce_pkg::op_none))
    |=> (insn_done_o && (exec_count == $past(exec_count) + 1'b1)))
    else $error("execution counter did not advance");

endmodule : cce_exec

// ===== include/cce_defs.svh
`ifndef CCE_DEFS_SVH
`define CCE_DEFS_SVH

// ****************************************************************
// instruction word layout
// ****************************************************************
`define CCE_INSN_W 14
`define CCE_OPC_MSB 13
`define CCE_OPC_LSB 8
`define CCE_SEL_BIT 7
`define CCE_FADDR_MSB 6
`define CCE_OPC_CLEAR 6'h01
`define CCE_OPC_COMPLEMENT 6'h09
`define CCE_INSN_WATCHDOG_CLEAR 14'h0064

// ****************************************************************
// register port map and fields
// ****************************************************************
`define CCE_REG_AW 4
`define CCE_REG_WORK 4'h0
`define CCE_REG_STATUS 4'h4
`define CCE_REG_CTRL 4'h8
`define CCE_REG_COUNT 4'hC
`define CCE_ST_ZERO 0
`define CCE_ST_POWERDOWN 1
`define CCE_ST_TIMEOUT 2
`define CCE_CTRL_EXEC_EN 0

// ****************************************************************
// reset values and counter width
// ****************************************************************
`define CCE_RST_FLAG_N 1'b1
`define CCE_RST_ZERO_FLAG 1'b0
`define CCE_RST_EXEC_EN 1'b1
`define CCE_COUNT_W 8

`endif

// ===== include/cce_pkg.sv
package cce_pkg;

  // ****************************************************************
  // four phases of one instruction cycle
  // ****************************************************************
  typedef enum logic [1:0] {
    q1_decode,
    q2_read,
    q3_process,
    q4_write
  } cce_phase_t;

  // ****************************************************************
  // operations handled by this block
  // ****************************************************************
  typedef enum logic [2:0] {
    op_none,
    clear_file_register_op,
    clear_accumulator_op,
    watchdog_clear_op,
    complement_file_op
  } cce_op_t;

endpackage : cce_pkg

// ===== verification/tb_clear_complement_exec.sv
module tb_clear_complement_exec;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic sys_clk_i;
  logic rst_i;
  logic [13:0] instr_i;
  logic instr_valid_i;
  logic [6:0] file_addr_o;
  logic file_rd_o;
  logic [7:0] file_rdata_i;
  logic file_we_o;
  logic [7:0] file_wdata_o;
  logic watchdog_clr_o;
  logic prescaler_clr_o;
  logic timeout_evt_i;
  logic sleep_evt_i;
  logic [7:0] w_o;
  logic z_flag_o;
  logic timeout_flag_n_o;
  logic powerdown_flag_n_o;
  logic insn_done_o;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic reg_wr_i;
  logic reg_rd_i;
  int mismatches;
  int checks;
  int cnt;

  cce_exec u_dut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .file_addr_o(file_addr_o),
    .file_rd_o(file_rd_o),
    .file_rdata_i(file_rdata_i),
    .file_we_o(file_we_o),
    .file_wdata_o(file_wdata_o),
    .watchdog_clr_o(watchdog_clr_o),
    .prescaler_clr_o(prescaler_clr_o),
    .timeout_evt_i(timeout_evt_i),
    .sleep_evt_i(sleep_evt_i),
    .w_o(w_o),
    .z_flag_o(z_flag_o),
    .timeout_flag_n_o(timeout_flag_n_o),
    .powerdown_flag_n_o(powerdown_flag_n_o),
    .insn_done_o(insn_done_o),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // edges since reset release; a multiple of four marks a q1 clock
  always @(posedge sys_clk_i) cnt <= rst_i ? 0 : cnt + 1;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_byte(reg_rdata_o, exp);
  endtask : reg_read

  // returns on the edge that opens a q1 clock, so the word is driven there
  task automatic align();
    int n;
    n = 0;
    while (cnt % 4 != 3 && n < 8)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 8)
    begin
      mismatches++;
      print_verdict();
    end
    @(posedge sys_clk_i);
  endtask : align

  // f = {file read, file write, zero flag, watchdog pulses, done}
  task automatic run_insn(input logic [13:0] ins, input logic vld,
    input logic [7:0] rd, input logic [7:0] wd, input logic [7:0] w,
    input logic [4:0] f);
    align();
    instr_i <= ins;
    instr_valid_i <= vld;
    file_rdata_i <= rd;
    @(posedge sys_clk_i);
    // drop valid so the word is not taken again in the next q1
    instr_valid_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk_bit(file_rd_o, f[4]);
    if (f[4])
      chk_byte({1'b0, file_addr_o}, {1'b0, ins[6:0]});
    @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    #1;
    chk_bit(file_we_o, f[3]);
    if (f[3])
      chk_byte(file_wdata_o, wd);
    chk_byte(w_o, w);
    chk_bit(z_flag_o, f[2]);
    chk_bit(watchdog_clr_o, f[1]);
    chk_bit(prescaler_clr_o, f[1]);
    chk_bit(insn_done_o, f[0]);
  endtask : run_insn

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    mismatches = 0;
    checks = 0;
    rst_i = 1'b1;
    instr_i = 14'h0000;
    instr_valid_i = 1'b0;
    file_rdata_i = 8'h00;
    timeout_evt_i = 1'b0;
    sleep_evt_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1;
    reg_read(4'h0, 8'h00);
    reg_read(4'h4, 8'h06);
    reg_read(4'h8, 8'h01);
    reg_read(4'hC, 8'h00);
    reg_read(4'h2, 8'h00);
    reg_write(4'h0, 8'h5A);
    reg_read(4'h0, 8'h5A);
    run_insn(14'h01FF, 1'b1, 8'h5A, 8'h00, 8'h5A, 5'h1D);
    run_insn(14'h0180, 1'b1, 8'hA5, 8'h00, 8'h5A, 5'h1D);
    run_insn(14'h0985, 1'b1, 8'hFF, 8'h00, 8'h5A, 5'h1D);
    run_insn(14'h0913, 1'b1, 8'h13, 8'h00, 8'hEC, 5'h11);
    run_insn(14'h017F, 1'b1, 8'h77, 8'h00, 8'h00, 5'h05);
    @(posedge sys_clk_i);
    timeout_evt_i <= 1'b1;
    sleep_evt_i <= 1'b1;
    @(posedge sys_clk_i);
    timeout_evt_i <= 1'b0;
    sleep_evt_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    reg_read(4'h4, 8'h01);
    run_insn(14'h0064, 1'b1, 8'h33, 8'h00, 8'h00, 5'h07);
    chk_bit(timeout_flag_n_o, 1'b1);
    chk_bit(powerdown_flag_n_o, 1'b1);
    reg_read(4'h4, 8'h07);
    // an instruction without valid must leave W, the flags, the file strobes and the counter untouched; file_addr_o still loads in q2
    run_insn(14'h01AA, 1'b0, 8'h44, 8'h00, 8'h00, 5'h04);
    reg_read(4'hC, 8'h06);
    reg_write(4'hC, 8'h00);
    reg_read(4'hC, 8'h00);
    reg_write(4'h0, 8'h5A);
    reg_write(4'h8, 8'h00);
    run_insn(14'h0100, 1'b1, 8'h00, 8'h00, 8'h5A, 5'h04);
    reg_read(4'h8, 8'h00);
    reg_write(4'h8, 8'h01);
    run_insn(14'h0100, 1'b1, 8'h00, 8'h00, 8'h00, 5'h05);
    print_verdict();
  end

endmodule : tb_clear_complement_exec
